// File: logic/dpw_map.vh
`ifndef DPW_MAP_VH
`define DPW_MAP_VH
`define DPW_ADDR_UPPER      5'h0B
`define DPW_MIDSCALE        8'h80
`define DPW_INSTR_CHAN_BIT  7
`define DPW_INSTR_RST_BIT   6
`define DPW_INSTR_SD_BIT    5
`define DPW_INSTR_OUT2_BIT  4
`define DPW_INSTR_OUT1_BIT  3
`define DPW_TAPS            256
`endif

// File: logic/dpw_sync2.v
`timescale 1ns/1ps
module dpw_sync2 (
    input  wire clk_sys_in,
    input  wire nrst_in,
    input  wire async_in,
    output wire sync_out
);
    reg meta_q;
    reg sync_q;
    always @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
    assign sync_out = sync_q;
endmodule

// File: logic/dpw_tap_channel.v
`timescale 1ns/1ps
`include "dpw_map.vh"
module dpw_tap_channel (
    input  wire         clk_sys_in,
    input  wire         nrst_in,
    input  wire         load_in,
    input  wire [7:0]   code_in,
    input  wire         shutdown_in,
    output wire [7:0]   code_out,
    output reg  [255:0] tap_sel_out,
    output reg          top_switch_out
);
    reg [7:0] code_q;
    always @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            code_q <= `DPW_MIDSCALE;
        end else if (load_in) begin
            code_q <= code_in;
        end
    end
    assign code_out = code_q;
    // Bit 0 is the bottom end; the top segment has no tap, so 255 stops one below
    always @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            tap_sel_out    <= 256'h0;
            top_switch_out <= 1'b0;
        end else begin
            // shutdown shorts to bottom, code kept
            tap_sel_out    <= shutdown_in ? 256'h1 : (256'h1 << code_q);
            top_switch_out <= ~shutdown_in;
        end
    end
endmodule

// File: logic/dpw_wiper_ctrl.v
`timescale 1ns/1ps
`include "dpw_map.vh"
module dpw_wiper_ctrl (
    input  wire         clk_sys_in,
    input  wire         nrst_in,
    input  wire         scl_in,
    input  wire         sda_in,
    output reg          sda_oe_n_out,
    output wire         sda_out,
    input  wire         address_pin_low_in,
    input  wire         address_pin_high_in,
    input  wire         shutdown_pin_n_in,
    output reg          logic_output_one_out,
    output reg          logic_output_two_out,
    output wire [7:0]   first_channel_code_out,
    output wire [7:0]   second_channel_code_out,
    output wire [255:0] first_channel_taps_out,
    output wire [255:0] second_channel_taps_out,
    output wire         first_channel_top_out,
    output wire         second_channel_top_out
);
    // Bus frame states
    localparam ST_IDLE  = 3'd0;
    localparam ST_ADDR  = 3'd1;
    localparam ST_ACK   = 3'd2;
    localparam ST_INSTR = 3'd3;
    localparam ST_DATA  = 3'd4;
    localparam ST_READ  = 3'd5;
    localparam ST_RACK  = 3'd6;

    wire scl_s;
    wire sda_s;
    wire ad0_s;
    wire ad1_s;
    wire shutdown_pin_n_n_s;

    // Bus lines and straps are async to the system clock
    dpw_sync2 u_sync_scl (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .async_in   (scl_in),
        .sync_out   (scl_s)
    );

    dpw_sync2 u_sync_sda (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .async_in   (sda_in),
        .sync_out   (sda_s)
    );

    dpw_sync2 u_sync_ad0 (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .async_in   (address_pin_low_in),
        .sync_out   (ad0_s)
    );

    dpw_sync2 u_sync_ad1 (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .async_in   (address_pin_high_in),
        .sync_out   (ad1_s)
    );

    dpw_sync2 u_sync_sdn (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .async_in   (shutdown_pin_n_in),
        .sync_out   (shutdown_pin_n_n_s)
    );

    reg        scl_q;
    reg        sda_q;
    reg [2:0]  state_q;
    reg [2:0]  bit_cnt_q;
    reg [7:0]  shift_q;
    reg        ack_next_q;     // Ack owed in the coming ninth pulse
    reg        is_read_q;
    reg        chan_q;
    reg        instr_done_q;
    // Shutdown bits stay until a new instruction to that channel
    reg        sd_one_q;
    reg        sd_two_q;
    reg [7:0]  tx_q;
    reg        load_one_q;
    reg        load_two_q;
    reg [7:0]  load_code_q;

    // Limitation: SCL high and low must each last four system clocks
    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    // Equal sync delay on both lines keeps their order
    // start and stop detection
    wire start_ev = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_ev  = scl_s & scl_q & ~sda_q & sda_s;
    wire [7:0] rx_byte = {shift_q[6:0], sda_s};
    wire [7:0] code_one;
    wire [7:0] code_two;

    // Open drain: only the enable moves
    assign sda_out = 1'b0;

    // Idle-high reset, so no false edge after reset
    always @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    always @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            state_q              <= ST_IDLE;
            bit_cnt_q            <= 3'd0;
            shift_q              <= 8'h00;
            ack_next_q           <= 1'b0;
            is_read_q            <= 1'b0;
            chan_q               <= 1'b0;
            instr_done_q         <= 1'b0;
            sd_one_q             <= 1'b0;
            sd_two_q             <= 1'b0;
            tx_q                 <= 8'h00;
            sda_oe_n_out         <= 1'b1;
            load_one_q           <= 1'b0;
            load_two_q           <= 1'b0;
            load_code_q          <= 8'h00;
            logic_output_one_out <= 1'b0;
            logic_output_two_out <= 1'b0;
        end else begin
            // Load strobes last one cycle
            load_one_q <= 1'b0;
            load_two_q <= 1'b0;
            if (start_ev) begin
                state_q      <= ST_ADDR;
                bit_cnt_q    <= 3'd0;
                sda_oe_n_out <= 1'b1;
            end else if (stop_ev) begin
                state_q      <= ST_IDLE;
                sda_oe_n_out <= 1'b1;
            end else begin
                case (state_q)
                ST_ADDR, ST_INSTR, ST_DATA: begin
                    // MSB first, eight bits then ack
                    if (scl_rise) begin
                        shift_q   <= rx_byte;
                        bit_cnt_q <= bit_cnt_q + 3'd1;
                        if (bit_cnt_q == 3'd7) begin
                            ack_next_q <= 1'b1;
                            if (state_q == ST_ADDR) begin
                                if (rx_byte[7:1] != {`DPW_ADDR_UPPER, ad1_s, ad0_s}) begin
                                    ack_next_q <= 1'b0;
                                end
                                is_read_q    <= rx_byte[0];
                                instr_done_q <= 1'b0;
                                // Captured now, so a later load cannot tear it
                                tx_q         <= chan_q ? code_two : code_one;
                            end else if (state_q == ST_INSTR) begin
                                chan_q <= rx_byte[`DPW_INSTR_CHAN_BIT];
                                logic_output_two_out <= rx_byte[`DPW_INSTR_OUT2_BIT];
                                logic_output_one_out <= rx_byte[`DPW_INSTR_OUT1_BIT];
                                if (rx_byte[`DPW_INSTR_CHAN_BIT]) begin
                                    sd_two_q <= rx_byte[`DPW_INSTR_SD_BIT];
                                end else begin
                                    sd_one_q <= rx_byte[`DPW_INSTR_SD_BIT];
                                end
                                if (rx_byte[`DPW_INSTR_RST_BIT]) begin
                                    load_code_q <= `DPW_MIDSCALE;
                                    load_one_q  <= ~rx_byte[`DPW_INSTR_CHAN_BIT];
                                    load_two_q  <= rx_byte[`DPW_INSTR_CHAN_BIT];
                                end
                                instr_done_q <= 1'b1;
                            end else begin
                                load_code_q <= rx_byte;
                                load_one_q  <= ~chan_q;
                                load_two_q  <= chan_q;
                            end
                            state_q <= ST_ACK;
                        end
                    end
                end
                ST_ACK: begin
                    // drive ack through ninth pulse, change on low
                    if (scl_fall && sda_oe_n_out && ack_next_q) begin
                        sda_oe_n_out <= 1'b0;
                    end else if (scl_fall && !sda_oe_n_out) begin
                        bit_cnt_q <= 3'd0;
                        if (is_read_q) begin
                            // first read bit right after ack
                            sda_oe_n_out <= tx_q[7];
                            tx_q         <= {tx_q[6:0], 1'b0};
                            state_q      <= ST_READ;
                        end else begin
                            sda_oe_n_out <= 1'b1;
                            state_q      <= instr_done_q ? ST_DATA : ST_INSTR;
                        end
                    end else if (scl_fall && !ack_next_q) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_READ: begin
                    if (scl_fall) begin
                        bit_cnt_q <= bit_cnt_q + 3'd1;
                        if (bit_cnt_q == 3'd7) begin
                            sda_oe_n_out <= 1'b1;
                            state_q      <= ST_RACK;
                        end else begin
                            sda_oe_n_out <= tx_q[7];
                            tx_q         <= {tx_q[6:0], 1'b0};
                        end
                    end
                end
                ST_RACK: begin
                    // Master ack repeats the read, nack ends it
                    if (scl_rise) begin
                        ack_next_q <= ~sda_s;
                        tx_q       <= chan_q ? code_two : code_one;
                    end else if (scl_fall) begin
                        if (ack_next_q) begin
                            bit_cnt_q    <= 3'd0;
                            sda_oe_n_out <= tx_q[7];
                            tx_q         <= {tx_q[6:0], 1'b0};
                            state_q      <= ST_READ;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_q      <= ST_IDLE;
                    sda_oe_n_out <= 1'b1;
                end
                endcase
            end
        end
    end

    // pin low or bit high, code untouched
    dpw_tap_channel u_chan_one (
        .clk_sys_in     (clk_sys_in),
        .nrst_in        (nrst_in),
        .load_in        (load_one_q),
        .code_in        (load_code_q),
        .shutdown_in    (sd_one_q | ~shutdown_pin_n_n_s),
        .code_out       (code_one),
        .tap_sel_out    (first_channel_taps_out),
        .top_switch_out (first_channel_top_out)
    );

    dpw_tap_channel u_chan_two (
        .clk_sys_in     (clk_sys_in),
        .nrst_in        (nrst_in),
        .load_in        (load_two_q),
        .code_in        (load_code_q),
        .shutdown_in    (sd_two_q | ~shutdown_pin_n_n_s),
        .code_out       (code_two),
        .tap_sel_out    (second_channel_taps_out),
        .top_switch_out (second_channel_top_out)
    );

    assign first_channel_code_out  = code_one;
    assign second_channel_code_out = code_two;
endmodule

// File: dv/dpw_wiper_ctrl_monitor.sv
`timescale 1ns/1ps
module dpw_wiper_ctrl_monitor (
    input wire         clk_sys_in,
    input wire         nrst_in,
    input wire         scl_in,
    input wire         shutdown_pin_n_in,
    input wire         sda_oe_n_out,
    input wire         sda_out,
    input wire         logic_output_one_out,
    input wire         logic_output_two_out,
    input wire [7:0]   first_channel_code_out,
    input wire [7:0]   second_channel_code_out,
    input wire [255:0] first_channel_taps_out,
    input wire         first_channel_top_out,
    input wire         second_channel_top_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    property p_onehot;
        nrst_in && $past(nrst_in) |-> $onehot(first_channel_taps_out);
    endproperty
    a_onehot: assert property (p_onehot) else $error("tap select not one-hot");
    property p_pos;
        $past(nrst_in) && $stable(first_channel_code_out) && first_channel_top_out
        && $past(first_channel_top_out) |-> first_channel_taps_out == (256'h1 << first_channel_code_out);
    endproperty
    a_pos: assert property (p_pos) else $error("tap does not follow code");
    property p_sd;
        $past(nrst_in) && !first_channel_top_out && !$past(first_channel_top_out)
        |-> first_channel_taps_out == 256'h1;
    endproperty
    a_sd: assert property (p_sd) else $error("shutdown tap not bottom");
    // Two sync flops plus a register, so six cycles is ample
    property p_pin;
        (!shutdown_pin_n_in) [*6] |-> !first_channel_top_out && !second_channel_top_out;
    endproperty
    a_pin: assert property (p_pin) else $error("pin shutdown not applied");
    property p_hold;
        (!scl_in) [*8] |-> $stable(first_channel_code_out) && $stable(second_channel_code_out);
    endproperty
    a_hold: assert property (p_hold) else $error("code moved while bus idle low");
    property p_oe;
        $changed(sda_oe_n_out) |-> !scl_in;
    endproperty
    a_oe: assert property (p_oe) else $error("data line moved while clock high");
    property p_drv;
        !sda_oe_n_out |-> sda_out == 1'b0;
    endproperty
    a_drv: assert property (p_drv) else $error("data line driven high");
    property p_outs;
        $changed(logic_output_one_out) || $changed(logic_output_two_out) |-> scl_in;
    endproperty
    a_outs: assert property (p_outs) else $error("logic output moved off a clock high");
    property p_mid;
        $rose(nrst_in) |-> first_channel_code_out == 8'h80 && second_channel_code_out == 8'h80
        && !logic_output_one_out && !logic_output_two_out;
    endproperty
    a_mid: assert property (p_mid) else $error("reset state wrong");
    c_ack: cover property ($fell(sda_oe_n_out));
    c_sd: cover property ($fell(first_channel_top_out));
    c_code: cover property ($changed(first_channel_code_out));
endmodule

// File: dv/dpw_i2c_master.sv
`timescale 1ns/1ps
module dpw_i2c_master (
    output logic scl_out,
    output logic sda_rel_out,
    input  wire  sda_in
);
    // Quarter of the 125 ns bus period
    localparam realtime QTR = 31.25;
    initial begin
        scl_out = 1'b1;
        sda_rel_out = 1'b1;
    end
    task bit_io(input logic b, output logic r);
        sda_rel_out = b;
        #QTR scl_out = 1'b1;
        #QTR r = sda_in;
        #QTR scl_out = 1'b0;
        #QTR;
    endtask
    task start;
        // Keep bus edges off the system clock edge
        #0.1;
        sda_rel_out = 1'b1;
        #QTR scl_out = 1'b1;
        #QTR sda_rel_out = 1'b0;
        #QTR scl_out = 1'b0;
        #QTR;
    endtask
    task stop;
        sda_rel_out = 1'b0;
        #QTR scl_out = 1'b1;
        #QTR sda_rel_out = 1'b1;
        #QTR;
    endtask
    task xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(last, ack);
    endtask
endmodule

// File: dv/test_i2c_digipot_wiper_control.sv
`timescale 1ns/1ps
module test_i2c_digipot_wiper_control;
    logic         clk_sys_in = 1'b0;
    logic         nrst_in = 1'b0;
    logic         shutdown_pin_n_n = 1'b1;
    logic [1:0]   apin = 2'b00;
    wire          scl, sda_rel, sda_oe_n, sda_o, out1, out2, top1, top2;
    wire  [7:0]   code1, code2;
    wire  [255:0] taps1, taps2;
    // Open drain with pull-up
    wire          sda_line = sda_rel & (sda_oe_n | sda_o);
    int           mismatches = 0;
    int           check_count = 0;
    int           code[2] = '{128, 128};
    int           sd[2] = '{0, 0};
    int           sel = 0, o1 = 0, o2 = 0;
    logic [7:0]   dq[$];
    logic [7:0]   rx;
    logic         ack;
    always #2 clk_sys_in = ~clk_sys_in;
    dpw_wiper_ctrl u_dpw_wiper_ctrl (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .scl_in(scl),
        .sda_in(sda_line), .sda_oe_n_out(sda_oe_n), .sda_out(sda_o),
        .address_pin_low_in(apin[0]), .address_pin_high_in(apin[1]), .shutdown_pin_n_in(shutdown_pin_n_n),
        .logic_output_one_out(out1), .logic_output_two_out(out2),
        .first_channel_code_out(code1), .second_channel_code_out(code2),
        .first_channel_taps_out(taps1), .second_channel_taps_out(taps2),
        .first_channel_top_out(top1), .second_channel_top_out(top2));
    dpw_i2c_master u_dpw_i2c_master (.scl_out(scl), .sda_rel_out(sda_rel), .sda_in(sda_line));
    task check(input logic [255:0] seen, input logic [255:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    function automatic logic [255:0] taps(int ch);
        return (sd[ch] || !shutdown_pin_n_n) ? 256'h1 : 256'h1 << code[ch];
    endfunction
    task chk_all;
        repeat (20) @(posedge clk_sys_in);
        check(code1, code[0]);
        check(code2, code[1]);
        check(out1, o1);
        check(out2, o2);
        check(top1, !(sd[0] || !shutdown_pin_n_n));
        check(top2, !(sd[1] || !shutdown_pin_n_n));
        check(taps1, taps(0));
        check(taps2, taps(1));
    endtask
    task send(input logic [6:0] ad, input logic [7:0] ins);
        logic hit;
        hit = (ad == {5'h0B, apin});
        u_dpw_i2c_master.start();
        u_dpw_i2c_master.xfer({ad, 1'b0}, 1'b1, rx, ack);
        check(ack, !hit);
        u_dpw_i2c_master.xfer(ins, 1'b1, rx, ack);
        check(ack, !hit);
        if (hit) begin
            sel = ins[7];
            sd[sel] = ins[5];
            o2 = ins[4];
            o1 = ins[3];
            if (ins[6])
                code[sel] = 128;
        end
        foreach (dq[i]) begin
            u_dpw_i2c_master.xfer(dq[i], 1'b1, rx, ack);
            check(ack, !hit);
            if (hit)
                code[sel] = dq[i];
        end
        u_dpw_i2c_master.stop();
    endtask
    task rd;
        u_dpw_i2c_master.start();
        u_dpw_i2c_master.xfer({5'h0B, apin, 1'b1}, 1'b1, rx, ack);
        check(ack, 1'b0);
        // Master ack asks for the byte again
        u_dpw_i2c_master.xfer(8'hFF, 1'b0, rx, ack);
        check(rx, code[sel]);
        u_dpw_i2c_master.xfer(8'hFF, 1'b1, rx, ack);
        check(rx, code[sel]);
        u_dpw_i2c_master.stop();
    endtask
    task results;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys_in);
        mismatches++;
        results();
    end
    initial begin
        void'($urandom(32'hC53A));
        repeat (8) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        apin <= 2'($urandom);
        chk_all();
        // Both channels, both output levels, codes 0 and 255
        for (int k = 0; k < 4; k++) begin
            dq = {8'($urandom), k[0] ? 8'hFF : 8'h00};
            send({5'h0B, apin}, {k[0], 2'b00, k[1], ~k[1], 3'($urandom)});
            chk_all();
            rd();
        end
        dq = {};
        send({5'h0B, apin}, 8'h40);
        chk_all();
        dq = {8'h3C};
        send({5'h0B, apin}, 8'hA0);
        chk_all();
        rd();
        dq = {};
        send({5'h0B, apin}, 8'h80);
        chk_all();
        @(posedge clk_sys_in) shutdown_pin_n_n <= 1'b0;
        dq = {8'h11};
        send({5'h0B, apin}, 8'h08);
        chk_all();
        shutdown_pin_n_n <= 1'b1;
        chk_all();
        for (int m = 0; m < 2; m++)
            send(m ? {5'h0A, apin} : {5'h0B, ~apin}, 8'h18);
        chk_all();
        // Stop in mid data byte leaves the code alone
        u_dpw_i2c_master.start();
        u_dpw_i2c_master.xfer({5'h0B, apin, 1'b0}, 1'b1, rx, ack);
        u_dpw_i2c_master.xfer(8'h18, 1'b1, rx, ack);
        {sel, o1, o2} = {32'd0, 32'd1, 32'd1};
        repeat (4) u_dpw_i2c_master.bit_io(1'b0, ack);
        u_dpw_i2c_master.stop();
        chk_all();
        rd();
        // Repeated start turns a write frame into a read of the new channel
        u_dpw_i2c_master.start();
        u_dpw_i2c_master.xfer({5'h0B, apin, 1'b0}, 1'b1, rx, ack);
        check(ack, 1'b0);
        u_dpw_i2c_master.xfer(8'h80, 1'b1, rx, ack);
        check(ack, 1'b0);
        {sel, o1, o2} = {32'd1, 32'd0, 32'd0};
        rd();
        chk_all();
        results();
    end
endmodule
bind dpw_wiper_ctrl dpw_wiper_ctrl_monitor u_dpw_wiper_ctrl_monitor (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .scl_in(scl_in),
    .shutdown_pin_n_in(shutdown_pin_n_in), .sda_oe_n_out(sda_oe_n_out), .sda_out(sda_out),
    .logic_output_one_out(logic_output_one_out), .logic_output_two_out(logic_output_two_out),
    .first_channel_code_out(first_channel_code_out),
    .second_channel_code_out(second_channel_code_out),
    .first_channel_taps_out(first_channel_taps_out),
    .first_channel_top_out(first_channel_top_out), .second_channel_top_out(second_channel_top_out));
